// ===== clm_pkg.sv
// constants shared by the configurable logic macrocell block
`default_nettype none
package clm_pkg;
	localparam int          NCELL       = 32;       // output cells, and input cells
	localparam int          NSYNC       = 5 * NCELL + NCELL + 1;
	localparam int          ADDR_W      = 8;
	// register byte offsets
	localparam logic [7:0]  OFS_COMB    = 8'h00;    // per cell: combinatorial form
	localparam logic [7:0]  OFS_LATCH   = 8'h04;    // per cell: latch form
	localparam logic [7:0]  OFS_INVERT  = 8'h08;    // per cell: inverted output
	localparam logic [7:0]  OFS_TOGGLE  = 8'h0C;    // per cell: toggle storage
	localparam logic [7:0]  OFS_CLKINV  = 8'h10;    // per cell: falling clock edge
	localparam logic [7:0]  OFS_INLATCH = 8'h14;    // per input cell: latch capture
	localparam logic [7:0]  OFS_OSTATE  = 8'h18;    // read only: output cell state
	localparam logic [7:0]  OFS_ISTATE  = 8'h1C;    // read only: input cell state
	// reset values
	localparam logic [31:0] RST_CFG     = 32'h0000_0000;
	localparam logic [31:0] RD_ZERO     = 32'h0000_0000;
endpackage : clm_pkg
`default_nettype wire

// ===== clm_macrocell.sv
// output and input macrocells with apb configuration registers
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`default_nettype none
module clm_macrocell
	import clm_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	input  wire logic [NCELL-1:0]  sum_term,
	input  wire logic [NCELL-1:0]  clk_term,
	input  wire logic [NCELL-1:0]  clr_term,
	input  wire logic [NCELL-1:0]  set_term,
	input  wire logic [NCELL-1:0]  oe_term,
	input  wire logic [NCELL-1:0]  in_pin,
	input  wire logic              in_clk,
	output var  logic [NCELL-1:0]  pin_out,
	output var  logic [NCELL-1:0]  pin_oe,
	output var  logic [NCELL-1:0]  in_q
);
	// configuration registers
	logic [NCELL-1:0] comb;
	logic [NCELL-1:0] latch;
	logic [NCELL-1:0] inv;
	logic [NCELL-1:0] toggle;
	logic [NCELL-1:0] clk_inv;
	logic [NCELL-1:0] in_latch;
	logic [NCELL-1:0] next_comb;
	logic [NCELL-1:0] next_latch;
	logic [NCELL-1:0] next_inv;
	logic [NCELL-1:0] next_toggle;
	logic [NCELL-1:0] next_clk_inv;
	logic [NCELL-1:0] next_in_latch;
	logic [31:0]      next_prdata;
	logic             next_pready;
	logic             next_pslverr;
	logic             wr_go;
	logic             hit;
	logic [31:0]      rd_val;

	// input synchroniser: three stages, filtered once stages two and three agree
	// every term and pin crosses in one vector so all cells see the same latency
	logic [NSYNC-1:0] s1;
	logic [NSYNC-1:0] s2;
	logic [NSYNC-1:0] s3;
	logic [NSYNC-1:0] filt;
	logic [NSYNC-1:0] filt_d;
	logic [NSYNC-1:0] next_filt;
	logic [NCELL-1:0] d_f;
	logic [NCELL-1:0] ck_f;
	logic [NCELL-1:0] ck_d;
	logic [NCELL-1:0] clr_f;
	logic [NCELL-1:0] set_f;
	logic [NCELL-1:0] oe_f;
	logic [NCELL-1:0] pin_f;
	logic             ick_f;
	logic             ick_d;

	// cell storage
	logic [NCELL-1:0] q;
	logic [NCELL-1:0] next_q;
	logic [NCELL-1:0] next_in_q;
	logic [NCELL-1:0] next_pin_out;
	logic [NCELL-1:0] edge_hit;
	logic [NCELL-1:0] en_lvl;
	logic             in_edge;

	// filter keeps its value while stages two and three disagree
	always_comb begin
		next_filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1     <= '0;
			s2     <= '0;
			s3     <= '0;
			filt   <= '0;
			filt_d <= '0;
		end else begin
			s1     <= {in_clk, in_pin, oe_term, set_term, clr_term, clk_term, sum_term};
			s2     <= s1;
			s3     <= s2;
			filt   <= next_filt;
			filt_d <= filt;
		end
	end

	// a bit whose second and third stages disagree keeps its filtered value,
	// so a pin caught mid-change cannot reach the cells as a one-cycle glitch
	a_filter_hold: assert property (@(posedge pclk) disable iff (!presetn)
		##1 ((filt ^ $past(filt)) & ($past(s2) ^ $past(s3))) == '0)
		else $error("filter moved while its stages disagreed");
	a_filter_take: assert property (@(posedge pclk) disable iff (!presetn)
		##1 ((filt ^ $past(s3)) & ~($past(s2) ^ $past(s3))) == '0)
		else $error("filter missed its agreeing stages");

	// split the filtered vector back into its groups
	assign d_f   = filt[0 +: NCELL];
	assign ck_f  = filt[NCELL +: NCELL];
	assign ck_d  = filt_d[NCELL +: NCELL];
	assign clr_f = filt[2*NCELL +: NCELL];
	assign set_f = filt[3*NCELL +: NCELL];
	assign oe_f  = filt[4*NCELL +: NCELL];
	assign pin_f = filt[5*NCELL +: NCELL];
	assign ick_f = filt[NSYNC-1];
	assign ick_d = filt_d[NSYNC-1];
	assign in_edge = ick_f & ~ick_d;

	// apb decode: read data and error taken in setup, write done at access end
	always_comb begin
		hit    = 1'b1;
		rd_val = RD_ZERO;
		unique case (paddr)
			OFS_COMB:    rd_val = comb;
			OFS_LATCH:   rd_val = latch;
			OFS_INVERT:  rd_val = inv;
			OFS_TOGGLE:  rd_val = toggle;
			OFS_CLKINV:  rd_val = clk_inv;
			OFS_INLATCH: rd_val = in_latch;
			OFS_OSTATE:  rd_val = q;
			OFS_ISTATE:  rd_val = in_q;
			default:     hit = 1'b0;
		endcase
		next_pready   = psel & ~penable;
		next_prdata   = (psel & ~penable & ~pwrite) ? rd_val : prdata;
		next_pslverr  = (psel & ~penable) ? ~hit : pslverr;
		wr_go         = psel & penable & pready & pwrite & ~pslverr;
		next_comb     = (wr_go && paddr == OFS_COMB)    ? pwdata : comb;
		next_latch    = (wr_go && paddr == OFS_LATCH)   ? pwdata : latch;
		next_inv      = (wr_go && paddr == OFS_INVERT)  ? pwdata : inv;
		next_toggle   = (wr_go && paddr == OFS_TOGGLE)  ? pwdata : toggle;
		next_clk_inv  = (wr_go && paddr == OFS_CLKINV)  ? pwdata : clk_inv;
		next_in_latch = (wr_go && paddr == OFS_INLATCH) ? pwdata : in_latch;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata   <= RD_ZERO;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			comb     <= RST_CFG;
			latch    <= RST_CFG;
			inv      <= RST_CFG;
			toggle   <= RST_CFG;
			clk_inv  <= RST_CFG;
			in_latch <= RST_CFG;
		end else begin
			prdata   <= next_prdata;
			pready   <= next_pready;
			pslverr  <= next_pslverr;
			comb     <= next_comb;
			latch    <= next_latch;
			inv      <= next_inv;
			toggle   <= next_toggle;
			clk_inv  <= next_clk_inv;
			in_latch <= next_in_latch;
		end
	end

	// apb phases shared by the bus properties below
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_write_done;
		psel && penable && pready && pwrite && !pslverr;
	endsequence

	// one wait-free access per setup, ready stands for a single cycle
	a_ready_after: assert property (@(posedge pclk) disable iff (!presetn)
		s_setup |=> pready)
		else $error("ready did not follow setup");
	a_ready_single: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready stood longer than one cycle");
	// error flag and read word come from the decode of the setup cycle
	a_error_decode: assert property (@(posedge pclk) disable iff (!presetn)
		s_setup |=> pslverr == !$past(hit))
		else $error("error flag wrong for address");
	a_read_word: assert property (@(posedge pclk) disable iff (!presetn)
		s_setup ##0 !pwrite |=> prdata == $past(rd_val))
		else $error("read data not taken from decode");
	// a write lands in the addressed register as its access ends
	a_write_invert: assert property (@(posedge pclk) disable iff (!presetn)
		s_write_done ##0 (paddr == OFS_INVERT) |=> inv == $past(pwdata))
		else $error("invert write did not land");
	a_write_form: assert property (@(posedge pclk) disable iff (!presetn)
		s_write_done ##0 (paddr == OFS_COMB) |=> comb == $past(pwdata))
		else $error("form write did not land");

	// per cell next state for output and input macrocells
	genvar i;
	generate
		for (i = 0; i < NCELL; i++) begin : g_cell
			always_comb begin
				// effective clock edge and latch level after polarity choice
				edge_hit[i] = (ck_f[i] ^ clk_inv[i]) & ~(ck_d[i] ^ clk_inv[i]);
				en_lvl[i]   = ck_f[i] ^ clk_inv[i];
				next_q[i]   = q[i];
				if (clr_f[i]) begin
					next_q[i] = 1'b0;
				end else if (set_f[i]) begin
					next_q[i] = 1'b1;
				end else if (comb[i]) begin
					next_q[i] = d_f[i];
				end else if (latch[i]) begin
					if (en_lvl[i]) begin
						next_q[i] = d_f[i];
					end
				end else if (edge_hit[i]) begin
					next_q[i] = toggle[i] ? (q[i] ^ d_f[i]) : d_f[i];
				end
				next_pin_out[i] = next_q[i] ^ inv[i];
				next_in_q[i]    = in_q[i];
				if (in_latch[i] ? ick_f : in_edge) begin
					next_in_q[i] = pin_f[i];
				end
			end

			// assertions for this cell
			a_clear_wins: assert property (@(posedge pclk) disable iff (!presetn)
				clr_f[i] |=> !q[i])
				else $error("clear did not force cell low");
			a_set_forces: assert property (@(posedge pclk) disable iff (!presetn)
				set_f[i] && !clr_f[i] |=> q[i])
				else $error("set did not force cell high");
			a_comb_follows: assert property (@(posedge pclk) disable iff (!presetn)
				!clr_f[i] && !set_f[i] && comb[i] |=> q[i] == $past(d_f[i]))
				else $error("combinatorial form did not follow data");
			a_latch_holds: assert property (@(posedge pclk) disable iff (!presetn)
				!clr_f[i] && !set_f[i] && !comb[i] && latch[i] && !en_lvl[i]
				|=> $stable(q[i]))
				else $error("closed latch changed");
			a_toggle_flip: assert property (@(posedge pclk) disable iff (!presetn)
				!clr_f[i] && !set_f[i] && !comb[i] && !latch[i] && toggle[i]
				&& edge_hit[i] && d_f[i] |=> q[i] != $past(q[i]))
				else $error("toggle storage did not invert");
			a_edge_only: assert property (@(posedge pclk) disable iff (!presetn)
				!clr_f[i] && !set_f[i] && !comb[i] && !latch[i]
				&& (ck_f[i] ^ clk_inv[i]) == (ck_d[i] ^ clk_inv[i]) |=> $stable(q[i]))
				else $error("register changed without its clock edge");
			a_pin_polarity: assert property (@(posedge pclk) disable iff (!presetn)
				##1 pin_out[i] == (q[i] ^ $past(inv[i])))
				else $error("pin polarity wrong");
			a_oe_follows: assert property (@(posedge pclk) disable iff (!presetn)
				##1 pin_oe[i] == $past(oe_f[i]))
				else $error("output enable did not follow its term");
			a_in_capture: assert property (@(posedge pclk) disable iff (!presetn)
				!in_latch[i] && in_edge |=> in_q[i] == $past(pin_f[i]))
				else $error("input register missed its pin");
			// a clocking edge reaches the storage only in the registered form
			sequence s_reg_edge;
				!clr_f[i] && !set_f[i] && !comb[i] && !latch[i] && edge_hit[i];
			endsequence
			a_dtype_load: assert property (@(posedge pclk) disable iff (!presetn)
				s_reg_edge ##0 !toggle[i] |=> q[i] == $past(d_f[i]))
				else $error("data storage did not load on its edge");
			a_toggle_hold: assert property (@(posedge pclk) disable iff (!presetn)
				s_reg_edge ##0 (toggle[i] && !d_f[i]) |=> $stable(q[i]))
				else $error("toggle storage changed with input low");
			a_latch_open: assert property (@(posedge pclk) disable iff (!presetn)
				!clr_f[i] && !set_f[i] && !comb[i] && latch[i] && en_lvl[i]
				|=> q[i] == $past(d_f[i]))
				else $error("open latch did not pass data");
			// input cells: a latch follows while open, both forms hold otherwise
			a_in_latch: assert property (@(posedge pclk) disable iff (!presetn)
				in_latch[i] && ick_f |=> in_q[i] == $past(pin_f[i]))
				else $error("open input latch did not pass its pin");
			a_in_hold: assert property (@(posedge pclk) disable iff (!presetn)
				(in_latch[i] ? !ick_f : !in_edge) |=> $stable(in_q[i]))
				else $error("input cell changed without capture");
		end
	endgenerate

	// 32 output and 32 input storage elements, pins and enables registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q       <= '0;
			in_q    <= '0;
			pin_out <= '0;
			pin_oe  <= '0;
		end else begin
			q       <= next_q;
			in_q    <= next_in_q;
			pin_out <= next_pin_out;
			pin_oe  <= oe_f;
		end
	end
endmodule : clm_macrocell
`default_nettype wire

// ===== clm_pla_model.sv
// model of the product-term array and input pins feeding the cells
`default_nettype none
module clm_pla_model
	import clm_pkg::*;
(
	input  wire logic             pclk,
	output var  logic [NCELL-1:0] sum_term,
	output var  logic [NCELL-1:0] clk_term,
	output var  logic [NCELL-1:0] clr_term,
	output var  logic [NCELL-1:0] set_term,
	output var  logic [NCELL-1:0] oe_term,
	output var  logic [NCELL-1:0] in_pin,
	output var  logic             in_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	// all terms low at start so no cell clocks or clears
	initial begin
		{sum_term, clk_term, clr_term, set_term, oe_term, in_pin, in_clk} = '0;
	end
	// new term levels land just after a rising edge
	task drive(input logic [NCELL-1:0] s, c, r, p, o);
		@(posedge pclk);
		sum_term <= s;
		clk_term <= c;
		clr_term <= r;
		set_term <= p;
		oe_term  <= o;
	endtask : drive
	// pin levels and the shared input clock
	task drive_in(input logic [NCELL-1:0] v, input logic k);
		@(posedge pclk);
		in_pin <= v;
		in_clk <= k;
	endtask : drive_in
endmodule : clm_pla_model
`default_nettype wire

// ===== configurable_logic_macrocell_tb_top.sv
// self-checking bench for the configurable logic macrocell block
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module configurable_logic_macrocell_tb_top
	import clm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] pa   = 32'hA5A5_A5A5;
	localparam logic [31:0] pb   = 32'h5A5A_5A5A;
	localparam logic [31:0] ones = 32'hFFFF_FFFF;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, in_clk, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, pin_out, pin_oe, in_q, in_pin;
	logic [31:0] sum_term, clk_term, clr_term, set_term, oe_term;
	int          miscompares, comparisons;
	clm_pla_model u_pla (.pclk, .sum_term, .clk_term, .clr_term, .set_term, .oe_term,
		.in_pin, .in_clk);
	clm_macrocell u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
		.pready, .pslverr, .sum_term, .clk_term, .clr_term, .set_term, .oe_term, .in_pin,
		.in_clk, .pin_out, .pin_oe, .in_q);
	// free-running bus clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// one apb transfer, held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// let the synchronisers and storage settle, then sample mid-cycle
	task settle();
		repeat (8) @(posedge pclk);
		@(negedge pclk);
	endtask : settle
	task step(input logic [31:0] s, c, r, p, o);
		u_pla.drive(s, c, r, p, o);
		settle();
	endtask : step
	task stepi(input logic [31:0] v, input logic k);
		u_pla.drive_in(v, k);
		settle();
	endtask : stepi
	task give_verdict();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict
	// cuts a hang short
	initial begin
		repeat (5000) @(posedge pclk);
		miscompares++;
		give_verdict();
	end
	// main test sequence
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, 8'(i * 4), '0);
			`CHK(rd, RST_CFG)
		end
		apb(1'b0, 8'h20, '0);
		`CHK(err, 1'b1)
		step(pa, '0, '0, '0, ones);
		step(pa, ones, '0, '0, ones);
		`CHK(pin_out, pa)
		`CHK(pin_oe, ones)
		apb(1'b1, OFS_INVERT, pb);
		settle();
		`CHK(pin_out, pa ^ pb)
		apb(1'b1, OFS_INVERT, '0);
		apb(1'b1, OFS_TOGGLE, ones);
		step(ones, '0, '0, '0, pb);
		`CHK(pin_oe, pb)
		step(ones, ones, '0, '0, pb);
		`CHK(pin_out, pb)
		step(pa, '0, '0, '0, '0);
		step(pa, ones, '0, '0, '0);
		`CHK(pin_out, ones)
		step('0, '0, pa, '0, '0);
		`CHK(pin_out, pb)
		step('0, '0, ones, ones, '0);
		`CHK(pin_out, '0)
		step('0, '0, '0, pa, '0);
		`CHK(pin_out, pa)
		apb(1'b0, OFS_OSTATE, '0);
		`CHK(rd, pa)
		apb(1'b1, OFS_TOGGLE, '0);
		step('0, '0, ones, '0, '0);
		apb(1'b1, OFS_CLKINV, ones);
		step(pa, ones, '0, '0, '0);
		`CHK(pin_out, '0)
		step(pa, '0, '0, '0, '0);
		`CHK(pin_out, pa)
		apb(1'b1, OFS_CLKINV, '0);
		apb(1'b1, OFS_COMB, ones);
		step(pb, '0, '0, '0, '0);
		`CHK(pin_out, pb)
		apb(1'b1, OFS_INVERT, ones);
		settle();
		`CHK(pin_out, pa)
		apb(1'b1, OFS_INVERT, '0);
		apb(1'b1, OFS_COMB, '0);
		apb(1'b1, OFS_LATCH, ones);
		step(pa, ones, '0, '0, '0);
		`CHK(pin_out, pa)
		step(pb, '0, '0, '0, '0);
		`CHK(pin_out, pa)
		apb(1'b1, OFS_LATCH, '0);
		stepi(pa, 1'b0);
		stepi(pa, 1'b1);
		`CHK(in_q, pa)
		stepi(pb, 1'b1);
		`CHK(in_q, pa)
		apb(1'b0, OFS_ISTATE, '0);
		`CHK(rd, pa)
		apb(1'b1, OFS_INLATCH, ones);
		settle();
		`CHK(in_q, pb)
		stepi(pa, 1'b0);
		`CHK(in_q, pb)
		apb(1'b1, OFS_OSTATE, ones);
		`CHK(err, 1'b0)
		give_verdict();
	end
endmodule : configurable_logic_macrocell_tb_top
`default_nettype wire
